//--- hdl/cpat_pkg.sv
package cpat_pkg;

    // ----------------------------------------
    // clock and time figures
    // ----------------------------------------
    localparam longint unsigned CLK_HZ = 64'h0000_0000_017D_7840;
    localparam longint unsigned TB_HZ = 64'h0000_0000_0012_2870;
    localparam longint unsigned UNIT_SHORT_S = 64'h0000_0000_0000_000F;
    localparam longint unsigned UNIT_LONG_MIN = 64'h0000_0000_0000_0001;
    localparam longint unsigned SEC_PER_MIN = 64'h0000_0000_0000_003C;
    localparam longint unsigned UNIT_SHORT_CYC = UNIT_SHORT_S * CLK_HZ;
    localparam longint unsigned UNIT_LONG_CYC = UNIT_LONG_MIN * SEC_PER_MIN * CLK_HZ;
    localparam longint unsigned TB_DIV_CYC = (CLK_HZ / TB_HZ) < 1 ? 1 : (CLK_HZ / TB_HZ);

    // ----------------------------------------
    // register indices, byte address is index times four
    // ----------------------------------------
    localparam logic [6:0] IDX_PWR_CTRL = 7'h2D;
    localparam logic [6:0] IDX_ACT_TMR = 7'h2E;
    localparam logic [6:0] IDX_TB_LO = 7'h30;
    localparam logic [6:0] IDX_TB_HI = 7'h31;
    localparam logic [6:0] IDX_IRQ_STAT = 7'h40;
    localparam logic [6:0] IDX_IRQ_EN = 7'h41;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int PC_MASK_BIT = 7;
    localparam int PC_JOIN_BIT = 6;
    localparam int PC_POL_BIT = 5;
    localparam int PC_SW_BIT = 4;
    localparam int AT_RES_BIT = 7;
    localparam int AT_CNT_MSB = 3;
    localparam int IRQ_TMO_BIT = 0;
    localparam int IRQ_OFF_BIT = 1;

    // ----------------------------------------
    // writable bits and reset values
    // ----------------------------------------
    localparam logic [7:0] PC_WR_MASK = 8'hF0;
    localparam logic [7:0] AT_WR_MASK = 8'h8F;
    localparam logic [7:0] PC_RST = 8'hA0;
    localparam logic [7:0] AT_RST = 8'h00;
    localparam logic [15:0] TB_RST = 16'h0000;
    localparam logic [1:0] IEN_RST = 2'h1;
    localparam logic PWR_OUT_RST = 1'h1;

endpackage : cpat_pkg

//--- hdl/cpat_tick_div.sv
`timescale 1ns/1ps
module cpat_tick_div #(
    parameter int W = 32
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic restart_in,
    input wire logic [W-1:0] period_in,
    output logic tick_out
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } cpat_div_t;

    cpat_div_t s;
    cpat_div_t next_s;

    if (W < 2) begin : g_chk
        $error("cpat_tick_div: width too small");
    end

    // ----------------------------------------
    // divider, restart clears the phase
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (restart_in) begin
            next_s.cnt = '0;
        end else if (s.cnt >= period_in - W'(1)) begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_out = s.tick;

    a_tick_single: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (s.tick && period_in > W'(1)) |=> !s.tick)
        else $error("tick lasted more than one cycle");

endmodule : cpat_tick_div

//--- hdl/cpat_activity_timer.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
// What this block does
// - The timeout interrupt mask bit resets to 1, and 0 enables the expiry interrupt.
// - With the join bit set the power manager request is ORed into card power.
// - The polarity bit picks the on level of the card power output, default high.
// - The power switch bit is ignored while the interrupt is masked or both slots are empty.
// - With the interrupt enabled and a card present the switch bit sets card power.
// - The resolution bit selects a 15 second or a 1 minute timer unit.
// - A nonzero timeout count enables the timer and zero disables it.
// - Each access to an enabled card restarts the idle time from zero.
// - Expiry with the interrupt enabled raises an interrupt and leaves power alone.
// - Expiry with the interrupt masked switches card power off.
// - After an automatic power-off only a write to the timer register restores power.
// - A 16-bit time-base counter counts up at 1.19 MHz from zero.
// - The time-base bytes read at indices 30h and 31h and ignore writes.
module cpat_activity_timer #(
    parameter longint unsigned P_UNIT_SHORT_CYCLES = cpat_pkg::UNIT_SHORT_CYC,
    parameter longint unsigned P_UNIT_LONG_CYCLES = cpat_pkg::UNIT_LONG_CYC
) (
    input wire logic CLK_SYS_IN,
    input wire logic SRST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [8:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic [1:0] CARD_PRESENT_IN,
    input wire logic CARD_ACCESS_IN,
    input wire logic PMU_POWER_REQUEST_IN,
    output logic CARD_POWER_OUT,
    output logic IRQ_OUT
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] ps1;
        logic [1:0] ps2;
        logic [7:0] pc;
        logic [7:0] at;
        logic [3:0] idle;
        logic expired;
        logic auto_off;
        logic [15:0] tb;
        logic [1:0] stat;
        logic [1:0] ien;
        logic ack;
        logic [7:0] dat;
        logic pwr;
        logic irq;
        logic [31:0] gap;
    } cpat_state_t;

    cpat_state_t s;
    cpat_state_t next_s;

    if (P_UNIT_SHORT_CYCLES < 1 || P_UNIT_LONG_CYCLES < 1 ||
        P_UNIT_SHORT_CYCLES > 64'h0000_0000_FFFF_FFFF ||
        P_UNIT_LONG_CYCLES > 64'h0000_0000_FFFF_FFFF) begin : g_chk
        $error("cpat_activity_timer: unit period out of range");
    end

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic [6:0] idx;
    logic pc_wr;
    logic at_wr;
    logic stat_rd;
    logic ien_wr;

    assign acc = WB_CYC_IN && WB_STB_IN && !s.ack;
    assign idx = WB_ADR_IN[8:2];
    assign wr = acc && WB_WE_IN && WB_SEL_IN[0];
    assign rd = acc && !WB_WE_IN;
    assign pc_wr = wr && idx == cpat_pkg::IDX_PWR_CTRL;
    assign at_wr = wr && idx == cpat_pkg::IDX_ACT_TMR;
    assign ien_wr = wr && idx == cpat_pkg::IDX_IRQ_EN;
    assign stat_rd = rd && idx == cpat_pkg::IDX_IRQ_STAT;

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    logic irq_masked;
    logic join_pmu;
    logic card_power_polarity;
    logic sw;
    logic res_long;
    logic [3:0] tmo;
    logic any_card;

    assign irq_masked = s.pc[cpat_pkg::PC_MASK_BIT];
    assign join_pmu = s.pc[cpat_pkg::PC_JOIN_BIT];
    assign card_power_polarity = s.pc[cpat_pkg::PC_POL_BIT];
    assign sw = s.pc[cpat_pkg::PC_SW_BIT];
    assign res_long = s.at[cpat_pkg::AT_RES_BIT];
    assign tmo = s.at[cpat_pkg::AT_CNT_MSB:0];
    assign any_card = |s.ps2;

    // ----------------------------------------
    // tick dividers
    // ----------------------------------------
    logic tb_tick;
    logic unit_tick;
    logic restart;
    logic [31:0] unit_period;

    assign restart = CARD_ACCESS_IN || at_wr;
    assign unit_period = res_long ? 32'(P_UNIT_LONG_CYCLES)
                                  : 32'(P_UNIT_SHORT_CYCLES);

    cpat_tick_div #(
        .W(32)
    ) u_tb_div (
        .clk_sys_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .restart_in(1'b0),
        .period_in(32'(cpat_pkg::TB_DIV_CYC)),
        .tick_out(tb_tick)
    );

    cpat_tick_div #(
        .W(32)
    ) u_unit_div (
        .clk_sys_in(CLK_SYS_IN),
        .srst_in(SRST_IN),
        .restart_in(restart),
        .period_in(unit_period),
        .tick_out(unit_tick)
    );

    // ----------------------------------------
    // expiry and power decision
    // ----------------------------------------
    logic expire_evt;
    logic tmr_on;
    logic pwr_on;

    assign expire_evt = unit_tick && tmo != 4'h0 && !s.expired && !restart &&
                        (s.idle + 4'h1) == tmo;

    always_comb begin
        tmr_on = 1'b1;
        if (s.auto_off) begin
            tmr_on = 1'b0;
        end else if (!irq_masked && any_card) begin
            tmr_on = sw;
        end else begin
            tmr_on = 1'b1;
        end
    end

    assign pwr_on = tmr_on || (join_pmu && PMU_POWER_REQUEST_IN);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    function automatic logic [7:0] read_byte(input cpat_state_t st, input logic [6:0] ix);
        logic [7:0] v;
        v = 8'h00;
        unique case (ix)
            cpat_pkg::IDX_PWR_CTRL: v = st.pc;
            cpat_pkg::IDX_ACT_TMR: v = st.at;
            cpat_pkg::IDX_TB_LO: v = st.tb[7:0];
            cpat_pkg::IDX_TB_HI: v = st.tb[15:8];
            cpat_pkg::IDX_IRQ_STAT: v = {6'h00, st.stat};
            cpat_pkg::IDX_IRQ_EN: v = {6'h00, st.ien};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.ps1 = CARD_PRESENT_IN;
        next_s.ps2 = s.ps1;
        next_s.ack = acc;
        next_s.dat = rd ? read_byte(s, idx) : 8'h00;
        if (pc_wr) begin
            next_s.pc = WB_DAT_IN[7:0] & cpat_pkg::PC_WR_MASK;
        end
        if (at_wr) begin
            next_s.at = WB_DAT_IN[7:0] & cpat_pkg::AT_WR_MASK;
        end
        if (ien_wr) begin
            next_s.ien = WB_DAT_IN[1:0];
        end
        if (restart) begin
            next_s.idle = 4'h0;
            next_s.expired = 1'b0;
        end else if (unit_tick && tmo != 4'h0 && !s.expired) begin
            next_s.idle = s.idle + 4'h1;
            next_s.expired = expire_evt;
        end
        if (at_wr) begin
            next_s.auto_off = 1'b0;
        end else if (expire_evt && irq_masked) begin
            next_s.auto_off = 1'b1;
        end
        next_s.stat = stat_rd ? 2'h0 : s.stat;
        next_s.stat[cpat_pkg::IRQ_TMO_BIT] = next_s.stat[cpat_pkg::IRQ_TMO_BIT] ||
                                             (expire_evt && !irq_masked);
        next_s.stat[cpat_pkg::IRQ_OFF_BIT] = next_s.stat[cpat_pkg::IRQ_OFF_BIT] ||
                                             (expire_evt && irq_masked);
        next_s.tb = s.tb + {15'h0000, tb_tick};
        next_s.pwr = pwr_on ~^ card_power_polarity;
        next_s.irq = |(next_s.stat & next_s.ien);
        if (restart) begin
            next_s.gap = 32'h0000_0000;
        end else if (unit_tick) begin
            next_s.gap = 32'h0000_0001;
        end else begin
            next_s.gap = s.gap + 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            s <= '0;
            s.pc <= cpat_pkg::PC_RST;
            s.at <= cpat_pkg::AT_RST;
            s.tb <= cpat_pkg::TB_RST;
            s.ien <= cpat_pkg::IEN_RST;
            s.pwr <= cpat_pkg::PWR_OUT_RST;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign WB_DAT_OUT = {24'h000000, s.dat};
    assign WB_ACK_OUT = s.ack;
    assign CARD_POWER_OUT = s.pwr;
    assign IRQ_OUT = s.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (SRST_IN);

    a_mask_reset: assert property (disable iff (1'b0)
        SRST_IN |=> s.pc[cpat_pkg::PC_MASK_BIT] && s.pc[cpat_pkg::PC_POL_BIT])
        else $error("mask or polarity bit wrong after reset");

    a_pmu_join: assert property (
        (join_pmu && PMU_POWER_REQUEST_IN) |=> CARD_POWER_OUT == $past(card_power_polarity))
        else $error("power manager request not joined");

    a_pol_flip: assert property (
        ($changed(card_power_polarity) && $stable(pwr_on)) |=> $changed(CARD_POWER_OUT))
        else $error("polarity change did not flip output");

    a_sw_ignored: assert property (
        (irq_masked && !s.auto_off && !join_pmu) |=> CARD_POWER_OUT == $past(card_power_polarity))
        else $error("switch bit not ignored while masked");

    a_sw_direct: assert property (
        (!irq_masked && any_card && !s.auto_off && !join_pmu)
        |=> CARD_POWER_OUT == ($past(sw) ~^ $past(card_power_polarity)))
        else $error("switch bit does not steer power");

    a_zero_disables: assert property (
        tmo == 4'h0 |-> !expire_evt ##1 !s.auto_off || $past(at_wr) || $past(s.auto_off))
        else $error("timer expired with zero count");

    a_access_restart: assert property (
        CARD_ACCESS_IN |=> s.idle == 4'h0 && !s.expired)
        else $error("card access did not restart idle count");

    a_irq_expire: assert property (
        (expire_evt && !irq_masked) |=> s.stat[cpat_pkg::IRQ_TMO_BIT] && !s.auto_off)
        else $error("expiry with interrupt enabled mishandled");

    a_auto_off: assert property (
        (expire_evt && irq_masked && !join_pmu)
        |=> s.auto_off ##1 CARD_POWER_OUT == !$past(card_power_polarity))
        else $error("automatic power-off missing");

    a_off_sticky: assert property (
        (s.auto_off && !at_wr) |=> s.auto_off)
        else $error("power restored without timer write");

    a_tb_count: assert property (
        tb_tick |=> s.tb == $past(s.tb) + 16'h0001)
        else $error("time-base did not count");

    a_tb_readonly: assert property (
        !tb_tick |=> s.tb == $past(s.tb))
        else $error("time-base changed without tick");

    a_expire_count: assert property (
        expire_evt |=> s.idle == $past(tmo) && s.expired)
        else $error("expiry at wrong idle count");

    a_write_restart: assert property (
        at_wr |=> s.idle == 4'h0 && !s.auto_off)
        else $error("timer write did not restart");

    a_unit_period: assert property (
        unit_tick |-> s.gap == unit_period)
        else $error("unit period does not match resolution");

    a_empty_ignored: assert property (
        (!irq_masked && !any_card && !s.auto_off && !join_pmu)
        |=> CARD_POWER_OUT == $past(card_power_polarity))
        else $error("switch bit not ignored with slots empty");

    a_off_power: assert property (
        (s.auto_off && !join_pmu) |=> CARD_POWER_OUT == !$past(card_power_polarity))
        else $error("power on during automatic power-off");

    a_off_event: assert property (
        (expire_evt && irq_masked) |=> s.stat[cpat_pkg::IRQ_OFF_BIT])
        else $error("power-off event not recorded");

    a_irq_level: assert property (
        (|(s.stat & s.ien)) |-> IRQ_OUT)
        else $error("interrupt output low with enabled status");

    a_ack_answer: assert property (
        (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT)
        else $error("bus request not acknowledged");

    a_ack_pulse: assert property (
        WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("bus ack longer than one cycle");

    c_expire_irq: cover property (expire_evt && !irq_masked);
    c_expire_off: cover property (expire_evt && irq_masked);
    c_stat_clear: cover property (stat_rd && s.stat != 2'h0);
    c_power_restore: cover property (s.auto_off && at_wr);
    c_pmu_join: cover property (join_pmu && PMU_POWER_REQUEST_IN && !tmr_on);

endmodule : cpat_activity_timer

//--- tb/cpat_card_model.sv
`timescale 1ns/1ps
module cpat_card_model (
    input wire logic clk_in,
    output logic [1:0] present_out,
    output logic access_out
);
    // --------
    // slots and card accesses
    // --------
    initial begin
        present_out = 2'h0;
        access_out = 1'b0;
    end
    task automatic insert(input logic [1:0] slots);
        @(posedge clk_in);
        present_out <= slots;
        repeat (3) @(posedge clk_in);
    endtask : insert
    task automatic access();
        @(posedge clk_in);
        access_out <= |present_out;
        @(posedge clk_in);
        access_out <= 1'b0;
    endtask : access
endmodule : cpat_card_model

//--- tb/tb_card_power_activity_timer.sv
`timescale 1ns/1ps
module tb_card_power_activity_timer;
    localparam int US = 20;
    localparam int UL = 40;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic pmu = 1'b0;
    logic [8:0] adr = 9'h000;
    logic [3:0] sel = 4'hF;
    logic [3:0] wsel = 4'hF;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [1:0] pres;
    logic acc;
    logic pwr;
    logic irq;
    int err_total = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    cpat_activity_timer #(.P_UNIT_SHORT_CYCLES(US), .P_UNIT_LONG_CYCLES(UL)) uut (
        .CLK_SYS_IN(clk), .SRST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .CARD_PRESENT_IN(pres), .CARD_ACCESS_IN(acc),
        .PMU_POWER_REQUEST_IN(pmu), .CARD_POWER_OUT(pwr), .IRQ_OUT(irq)
    );
    cpat_card_model card (.clk_in(clk), .present_out(pres), .access_out(acc));
    // --------
    // shared tasks
    // --------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= {idx, 2'h0};
        wdat <= {24'h000000, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (i == 20) begin
            err_total++;
            $display("ERROR wb_ack expected 1 seen 0");
            stop_test();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr
    task automatic rd(input logic [6:0] idx, input logic [7:0] e, input string what);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(what, {24'h000000, e}, q);
    endtask : rd
    task automatic wait_for(input logic k, input logic lvl, input int max, output int n);
        for (n = 1; n <= max; n++) begin
            @(negedge clk);
            if ((k ? pwr : irq) === lvl) return;
        end
    endtask : wait_for
    function automatic logic [31:0] in_rng(input logic [31:0] n, input logic [31:0] lo,
                                           input logic [31:0] hi);
        return {31'h0, (n >= lo && n <= hi)};
    endfunction : in_rng
    // --------
    // scenarios
    // --------
    task automatic t_regs();
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        chk("card_power", 32'h1, {31'h0, pwr});
        rd(cpat_pkg::IDX_PWR_CTRL, 8'hA0, "pwr_ctrl");
        rd(cpat_pkg::IDX_ACT_TMR, 8'h00, "act_tmr");
        rd(cpat_pkg::IDX_TB_HI, 8'h00, "tb_hi");
        rd(cpat_pkg::IDX_IRQ_EN, 8'h01, "irq_en");
        wr(cpat_pkg::IDX_ACT_TMR, 8'hFF);
        rd(cpat_pkg::IDX_ACT_TMR, cpat_pkg::AT_WR_MASK, "act_tmr_wr");
        wr(cpat_pkg::IDX_ACT_TMR, 8'h00);
        wsel = 4'hE;
        wr(cpat_pkg::IDX_ACT_TMR, 8'h8F);
        wsel = 4'hF;
        rd(cpat_pkg::IDX_ACT_TMR, 8'h00, "act_tmr_sel");
        rd(7'h10, 8'h00, "unmapped");
        bus(1'b0, cpat_pkg::IDX_TB_LO, 8'h00, a);
        wr(cpat_pkg::IDX_TB_LO, 8'hFF);
        wr(cpat_pkg::IDX_TB_HI, 8'hFF);
        bus(1'b0, cpat_pkg::IDX_TB_LO, 8'h00, b);
        chk("tb_lo_ro", 32'h1, in_rng(b - a, 0, 2));
        repeat (210) @(posedge clk);
        bus(1'b0, cpat_pkg::IDX_TB_LO, 8'h00, c);
        chk("tb_rate", 32'h1, in_rng(c - b, 10, 11));
        rd(cpat_pkg::IDX_TB_HI, 8'h00, "tb_hi_ro");
        $display("test regs done");
    endtask : t_regs
    task automatic t_power();
        logic [10:0] tab [8] = '{11'h102, 11'h183, 11'h101, 11'h503,
                                 11'h106, 11'h307, 11'h002, 11'h083};
        logic [10:0] e;
        for (int i = 0; i < 8; i++) begin
            e = tab[i];
            @(posedge clk);
            pmu <= e[2];
            card.insert(i[0] ? {e[1], 1'b0} : {1'b0, e[1]});
            wr(cpat_pkg::IDX_PWR_CTRL, e[10:3]);
            repeat (2) @(negedge clk);
            chk("card_power", {31'h0, e[0] ~^ e[8]}, {31'h0, pwr});
        end
        $display("test power done");
    endtask : t_power
    task automatic t_irq();
        int n;
        wr(cpat_pkg::IDX_PWR_CTRL, 8'h30);
        wr(cpat_pkg::IDX_ACT_TMR, 8'h01);
        repeat (4) begin
            repeat (US - 6) @(posedge clk);
            card.access();
        end
        chk("irq_idle", 32'h0, {31'h0, irq});
        wait_for(1'b0, 1'b1, US + 20, n);
        chk("irq_delay", 32'h1, in_rng(n, US - 4, US + 8));
        chk("card_power", 32'h1, {31'h0, pwr});
        rd(cpat_pkg::IDX_IRQ_STAT, 8'h01, "irq_stat");
        @(negedge clk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        $display("test irq done");
    endtask : t_irq
    task automatic t_auto_off();
        int n;
        wr(cpat_pkg::IDX_IRQ_EN, 8'h00);
        wr(cpat_pkg::IDX_PWR_CTRL, 8'hA0);
        wr(cpat_pkg::IDX_ACT_TMR, 8'h01);
        wait_for(1'b1, 1'b0, US + 20, n);
        chk("off_delay", 32'h1, in_rng(n, US - 4, US + 8));
        card.access();
        repeat (US) @(negedge clk);
        chk("card_power", 32'h0, {31'h0, pwr});
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(cpat_pkg::IDX_IRQ_EN, 8'h02);
        @(negedge clk);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        rd(cpat_pkg::IDX_IRQ_STAT, 8'h02, "irq_stat");
        @(negedge clk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        wr(cpat_pkg::IDX_ACT_TMR, 8'h00);
        repeat (2) @(negedge clk);
        chk("card_power", 32'h1, {31'h0, pwr});
        repeat (US * 3) @(negedge clk);
        chk("card_power", 32'h1, {31'h0, pwr});
        rd(cpat_pkg::IDX_IRQ_STAT, 8'h00, "irq_stat");
        $display("test auto_off done");
    endtask : t_auto_off
    task automatic t_res();
        int n;
        wr(cpat_pkg::IDX_IRQ_EN, 8'h01);
        wr(cpat_pkg::IDX_PWR_CTRL, 8'h30);
        wr(cpat_pkg::IDX_ACT_TMR, 8'h81);
        wait_for(1'b0, 1'b1, UL + 20, n);
        chk("irq_delay", 32'h1, in_rng(n, UL - 4, UL + 8));
        rd(cpat_pkg::IDX_IRQ_STAT, 8'h01, "irq_stat");
        wr(cpat_pkg::IDX_ACT_TMR, 8'h00);
        $display("test resolution done");
    endtask : t_res
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_power();
        t_irq();
        t_auto_off();
        t_res();
        stop_test();
    end
endmodule : tb_card_power_activity_timer
